// File: shared/hbc_pkg.sv
// Constants shared by the hardware break-condition matcher
package hbc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CH_STRIDE = 8'h20;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_ADDR      = 8'h04;
    localparam logic [7:0] OFS_AMASK     = 8'h08;
    localparam logic [7:0] OFS_DATA      = 8'h0C;
    localparam logic [7:0] OFS_DMASK     = 8'h10;
    localparam logic [7:0] OFS_SPID      = 8'h14;
    localparam logic [7:0] OFS_COUNT     = 8'h40;
    localparam logic [7:0] OFS_STATUS    = 8'h44;
    localparam logic [7:0] OFS_CNTVAL    = 8'h48;

    // Control field positions
    localparam int CTL_AMODE_LSB = 0;
    localparam int CTL_AMASK_EN  = 3;
    localparam int CTL_DMODE_LSB = 4;
    localparam int CTL_DMASK_EN  = 7;
    localparam int CTL_SPID_EN   = 8;
    localparam int CTL_CYC_LSB   = 9;
    localparam int CTL_DIR_LSB   = 11;
    localparam int CTL_CH_EN     = 13;
    localparam int CTL_WIDTH     = 14;

    // Address modes
    localparam logic [2:0] AM_DC     = 3'h0;
    localparam logic [2:0] AM_ADDR   = 3'h1;
    localparam logic [2:0] AM_FETCHB = 3'h2;
    localparam logic [2:0] AM_FETCHA = 3'h3;
    localparam logic [2:0] AM_XBUS   = 3'h4;
    localparam logic [2:0] AM_YBUS   = 3'h5;

    // Data modes
    localparam logic [2:0] DM_DC    = 3'h0;
    localparam logic [2:0] DM_BYTE  = 3'h1;
    localparam logic [2:0] DM_WORD  = 3'h2;
    localparam logic [2:0] DM_LONG  = 3'h3;
    localparam logic [2:0] DM_XDATA = 3'h4;
    localparam logic [2:0] DM_YDATA = 3'h5;

    // Cycle types and directions
    localparam logic [1:0] CY_ANY   = 2'h0;
    localparam logic [1:0] CY_EXEC  = 2'h1;
    localparam logic [1:0] CY_DMA   = 2'h2;
    localparam logic [1:0] DIR_ANY  = 2'h0;
    localparam logic [1:0] DIR_RD   = 2'h1;
    localparam logic [1:0] DIR_WR   = 2'h2;

    // Access size codes on the core bus
    localparam logic [1:0] SZ_BYTE  = 2'h0;
    localparam logic [1:0] SZ_WORD  = 2'h1;
    localparam logic [1:0] SZ_LONG  = 2'h2;

    // Reset values and limits
    localparam logic [CTL_WIDTH-1:0] RST_CTRL = 14'h0000;
    localparam logic [7:0]  RST_SPID  = 8'h00;
    localparam logic [11:0] RST_COUNT = 12'h001;
    localparam logic [11:0] MAX_COUNT = 12'hFFF;
endpackage

// File: hdl/hbc_channel.sv
// One break channel: qualifier comparison against the core buses
`timescale 1ns/1ns
module hbc_channel
    import hbc_pkg::*;
#(
    parameter bit HAS_XY   = 1'b1,
    parameter bit HAS_DATA = 1'b1,
    parameter bit HAS_SPID = 1'b1
) (
    // Configuration
    input  wire logic [CTL_WIDTH-1:0] ctrl,
    input  wire logic [31:0]          addr_cmp,
    input  wire logic [31:0]          addr_mask,
    input  wire logic [31:0]          data_cmp,
    input  wire logic [31:0]          data_mask,
    input  wire logic [7:0]           spid_cmp,
    // Core bus
    input  wire logic                 cpu_valid,
    input  wire logic [31:0]          cpu_addr,
    input  wire logic [31:0]          cpu_data,
    input  wire logic                 cpu_wr,
    input  wire logic [1:0]           cpu_size,
    input  wire logic                 cpu_fetch,
    input  wire logic                 cpu_dma,
    input  wire logic [7:0]           cpu_spid,
    input  wire logic                 retire_valid,
    input  wire logic [31:0]          retire_pc,
    // Operand buses
    input  wire logic                 xbus_valid,
    input  wire logic [31:0]          xbus_addr,
    input  wire logic [31:0]          xbus_data,
    input  wire logic                 xbus_wr,
    input  wire logic                 ybus_valid,
    input  wire logic [31:0]          ybus_addr,
    input  wire logic [31:0]          ybus_data,
    input  wire logic                 ybus_wr,
    // Result
    output logic                      hit
);
    logic [2:0]  amode;
    logic [2:0]  dmode;
    logic [1:0]  cyc;
    logic [1:0]  dir;
    logic        ev, a_ok, d_ok, c_ok, w_ok, s_ok, fetch_mode, wr, mask_on;
    logic [31:0] a_val, am, dm, d_diff;

    assign amode   = ctrl[CTL_AMODE_LSB +: 3];
    assign dmode   = HAS_DATA ? ctrl[CTL_DMODE_LSB +: 3] : DM_DC;
    assign cyc     = ctrl[CTL_CYC_LSB +: 2];
    assign dir     = ctrl[CTL_DIR_LSB +: 2];
    assign fetch_mode = (amode == AM_FETCHB) || (amode == AM_FETCHA);
    assign mask_on = ctrl[CTL_AMASK_EN] && !fetch_mode;
    assign am      = mask_on ? addr_mask : 32'h0000_0000;
    assign dm      = ctrl[CTL_DMASK_EN] ? data_mask : 32'h0000_0000;

    always_comb begin
        ev    = cpu_valid;
        a_val = cpu_addr;
        wr    = cpu_wr;
        case (amode)
            AM_DC:     ev = cpu_valid | xbus_valid | ybus_valid;
            AM_ADDR:   ev = cpu_valid;
            AM_FETCHB: ev = cpu_valid & cpu_fetch;
            AM_FETCHA: begin
                ev    = retire_valid;
                a_val = retire_pc;
            end
            AM_XBUS: begin
                ev    = HAS_XY & xbus_valid;
                a_val = xbus_addr;
                wr    = xbus_wr;
            end
            AM_YBUS: begin
                ev    = HAS_XY & ybus_valid;
                a_val = ybus_addr;
                wr    = ybus_wr;
            end
            default: ev = 1'b0;
        endcase
    end

    // Don't-care address passes any cycle
    assign a_ok = (amode == AM_DC) || (((a_val ^ addr_cmp) & ~am) == 32'h0000_0000);

    always_comb begin
        d_diff = (cpu_data ^ data_cmp) & ~dm;
        case (dmode)
            DM_DC:    d_ok = 1'b1;
            DM_BYTE:  d_ok = cpu_valid && cpu_size == SZ_BYTE && d_diff[7:0] == 8'h00;
            DM_WORD:  d_ok = cpu_valid && cpu_size == SZ_WORD && d_diff[15:0] == 16'h0000;
            DM_LONG:  d_ok = cpu_valid && cpu_size == SZ_LONG && d_diff == 32'h0000_0000;
            DM_XDATA: d_ok = xbus_valid && ((xbus_data ^ data_cmp) & ~dm) == 32'h0;
            DM_YDATA: d_ok = ybus_valid && ((ybus_data ^ data_cmp) & ~dm) == 32'h0;
            default:  d_ok = 1'b0;
        endcase
    end

    // Cycle type and direction
    always_comb begin
        case (cyc)
            CY_ANY:  c_ok = 1'b1;
            CY_EXEC: c_ok = !cpu_dma;
            CY_DMA:  c_ok = cpu_valid && cpu_dma;
            default: c_ok = 1'b0;
        endcase
        case (dir)
            DIR_ANY: w_ok = 1'b1;
            DIR_RD:  w_ok = !wr;
            DIR_WR:  w_ok = wr;
            default: w_ok = 1'b0;
        endcase
    end

    assign s_ok = !HAS_SPID || !ctrl[CTL_SPID_EN] || cpu_spid == spid_cmp;

    // Fetch modes combine only address and identifier
    assign hit = ctrl[CTL_CH_EN] && ev && a_ok && s_ok
                 && (fetch_mode || (d_ok && c_ok && w_ok));
endmodule

// File: hdl/hbc_matcher.sv
// Hardware break-condition matcher with Avalon-MM register access
`timescale 1ns/1ns
module hbc_matcher
    import hbc_pkg::*;
#(
    parameter bit HAS_MMU = 1'b1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Core bus
    input  wire logic        cpu_valid,
    input  wire logic [31:0] cpu_addr,
    input  wire logic [31:0] cpu_data,
    input  wire logic        cpu_wr,
    input  wire logic [1:0]  cpu_size,
    input  wire logic        cpu_fetch,
    input  wire logic        cpu_dma,
    input  wire logic [7:0]  cpu_address_space_identifier,
    input  wire logic        retire_valid,
    input  wire logic [31:0] retire_pc,
    // Operand buses
    input  wire logic        xbus_valid,
    input  wire logic [31:0] xbus_addr,
    input  wire logic [31:0] xbus_data,
    input  wire logic        xbus_wr,
    input  wire logic        ybus_valid,
    input  wire logic [31:0] ybus_addr,
    input  wire logic [31:0] ybus_data,
    input  wire logic        ybus_wr,
    // Break request and per-channel hit pulses
    output logic             break_req,
    output logic [1:0]       chan_hit
);
    logic [CTL_WIDTH-1:0] ctrl_reg  [2];
    logic [31:0]          addr_reg  [2];
    logic [31:0]          amask_reg [2];
    logic [31:0]          data_reg;
    logic [31:0]          dmask_reg;
    logic [7:0]           spid_reg  [2];
    logic [11:0]          count_reg;
    logic [11:0]          cnt_reg;
    logic [1:0]           status_reg;
    logic                 ack_reg;
    logic [31:0]          readdata_reg;
    logic                 break_req_reg;
    logic [1:0]           chan_hit_reg;

    logic [31:0]          readdata_next;
    logic [1:0]           hit;
    logic                 cnt_done;
    logic                 wr_acc;
    logic                 req;
    logic                 ch_sel;
    logic [7:0]           ch_ofs;
    logic                 in_ch;
    logic [31:0]          bmask;
    logic [31:0]          ctrl_wr;

    // Byte lanes to bit mask
    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction
    assign ctrl_wr = merge({18'h00000, ctrl_reg[ch_sel]}, avs_writedata, bmask);

    // Avalon answer: one wait cycle, then the access completes
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign wr_acc          = avs_write && ack_reg;
    assign avs_readdata    = readdata_reg;

    assign in_ch  = avs_address < (OFS_CH_STRIDE << 1);
    assign ch_sel = avs_address >= OFS_CH_STRIDE;
    assign ch_ofs = ch_sel ? avs_address - OFS_CH_STRIDE : avs_address;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && !ack_reg;
        end
    end

    // Channel configuration registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_reg[i]  <= RST_CTRL;
                addr_reg[i]  <= 32'h0000_0000;
                amask_reg[i] <= 32'h0000_0000;
                spid_reg[i]  <= RST_SPID;
            end
            data_reg  <= 32'h0000_0000;
            dmask_reg <= 32'h0000_0000;
        end else if (wr_acc && in_ch) begin
            case (ch_ofs)
                OFS_CTRL: begin
                    ctrl_reg[ch_sel] <= ctrl_wr[CTL_WIDTH-1:0];
                    // Channel 2 has no operand-bus or data selections
                    if (ch_sel) begin
                        if (avs_writedata[CTL_AMODE_LSB +: 3] == AM_XBUS
                            || avs_writedata[CTL_AMODE_LSB +: 3] == AM_YBUS) begin
                            ctrl_reg[1][CTL_AMODE_LSB +: 3] <= AM_DC;
                        end
                        ctrl_reg[1][CTL_DMODE_LSB +: 3] <= DM_DC;
                        ctrl_reg[1][CTL_DMASK_EN]       <= 1'b0;
                    end
                end
                OFS_ADDR:  addr_reg[ch_sel]  <= merge(addr_reg[ch_sel], avs_writedata, bmask);
                OFS_AMASK: amask_reg[ch_sel] <= merge(amask_reg[ch_sel], avs_writedata, bmask);
                OFS_DATA: begin
                    if (!ch_sel) begin
                        data_reg <= merge(data_reg, avs_writedata, bmask);
                    end
                end
                OFS_DMASK: begin
                    if (!ch_sel) begin
                        dmask_reg <= merge(dmask_reg, avs_writedata, bmask);
                    end
                end
                OFS_SPID: begin
                    if (HAS_MMU && avs_byteenable[0]) begin
                        spid_reg[ch_sel] <= avs_writedata[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Satisfaction count for channel 1
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_reg <= RST_COUNT;
        end else if (wr_acc && avs_address == OFS_COUNT && avs_byteenable[0]) begin
            count_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) begin
                count_reg[11:8] <= avs_writedata[11:8];
            end
        end else if (wr_acc && avs_address == OFS_COUNT && avs_byteenable[1]) begin
            count_reg[11:8] <= avs_writedata[11:8];
        end
    end

    // Zero is taken as one: every match breaks
    assign cnt_done = hit[0] && (cnt_reg + 12'h001 >= count_reg);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= 12'h000;
        end else if (wr_acc && avs_address == OFS_COUNT) begin
            cnt_reg <= 12'h000;
        end else if (hit[0]) begin
            cnt_reg <= cnt_done ? 12'h000 : cnt_reg + 12'h001;
        end
    end

    // Sticky hit flags, write one to clear, a new hit wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hit[i]) begin
                    status_reg[i] <= 1'b1;
                end else if (wr_acc && avs_address == OFS_STATUS
                             && avs_byteenable[0] && avs_writedata[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Break request and hit pulses, one cycle after the matching bus cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            break_req_reg <= 1'b0;
            chan_hit_reg  <= 2'h0;
        end else begin
            break_req_reg <= cnt_done || hit[1];
            chan_hit_reg  <= hit;
        end
    end
    assign break_req = break_req_reg;
    assign chan_hit  = chan_hit_reg;

    // Read data
    always_comb begin
        readdata_next = 32'h0000_0000;
        if (in_ch) begin
            case (ch_ofs)
                OFS_CTRL:  readdata_next = {18'h00000, ctrl_reg[ch_sel]};
                OFS_ADDR:  readdata_next = addr_reg[ch_sel];
                OFS_AMASK: readdata_next = amask_reg[ch_sel];
                OFS_DATA:  readdata_next = ch_sel ? 32'h0000_0000 : data_reg;
                OFS_DMASK: readdata_next = ch_sel ? 32'h0000_0000 : dmask_reg;
                OFS_SPID:  readdata_next = {24'h000000, spid_reg[ch_sel]};
                default:   readdata_next = 32'h0000_0000;
            endcase
        end else begin
            case (avs_address)
                OFS_COUNT:  readdata_next = {20'h00000, count_reg};
                OFS_STATUS: readdata_next = {30'h0, status_reg};
                OFS_CNTVAL: readdata_next = {20'h00000, cnt_reg};
                default:    readdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            readdata_reg <= readdata_next;
        end
    end

    // Channel 1: full qualifier set
    hbc_channel #(
        .HAS_XY   (1'b1),
        .HAS_DATA (1'b1),
        .HAS_SPID (HAS_MMU)
    ) u_ch1 (
        .ctrl         (ctrl_reg[0]),
        .addr_cmp     (addr_reg[0]),
        .addr_mask    (amask_reg[0]),
        .data_cmp     (data_reg),
        .data_mask    (dmask_reg),
        .spid_cmp     (spid_reg[0]),
        .cpu_valid    (cpu_valid),
        .cpu_addr     (cpu_addr),
        .cpu_data     (cpu_data),
        .cpu_wr       (cpu_wr),
        .cpu_size     (cpu_size),
        .cpu_fetch    (cpu_fetch),
        .cpu_dma      (cpu_dma),
        .cpu_spid     (cpu_address_space_identifier),
        .retire_valid (retire_valid),
        .retire_pc    (retire_pc),
        .xbus_valid   (xbus_valid),
        .xbus_addr    (xbus_addr),
        .xbus_data    (xbus_data),
        .xbus_wr      (xbus_wr),
        .ybus_valid   (ybus_valid),
        .ybus_addr    (ybus_addr),
        .ybus_data    (ybus_data),
        .ybus_wr      (ybus_wr),
        .hit          (hit[0])
    );

    // Channel 2: no operand-bus address modes, no data; its don't-care mode still takes xbus and ybus cycles
    hbc_channel #(
        .HAS_XY   (1'b0),
        .HAS_DATA (1'b0),
        .HAS_SPID (HAS_MMU)
    ) u_ch2 (
        .ctrl         (ctrl_reg[1]),
        .addr_cmp     (addr_reg[1]),
        .addr_mask    (amask_reg[1]),
        .data_cmp     (32'h0000_0000),
        .data_mask    (32'h0000_0000),
        .spid_cmp     (spid_reg[1]),
        .cpu_valid    (cpu_valid),
        .cpu_addr     (cpu_addr),
        .cpu_data     (cpu_data),
        .cpu_wr       (cpu_wr),
        .cpu_size     (cpu_size),
        .cpu_fetch    (cpu_fetch),
        .cpu_dma      (cpu_dma),
        .cpu_spid     (cpu_address_space_identifier),
        .retire_valid (retire_valid),
        .retire_pc    (retire_pc),
        .xbus_valid   (xbus_valid),
        .xbus_addr    (xbus_addr),
        .xbus_data    (xbus_data),
        .xbus_wr      (xbus_wr),
        .ybus_valid   (ybus_valid),
        .ybus_addr    (ybus_addr),
        .ybus_data    (ybus_data),
        .ybus_wr      (ybus_wr),
        .hit          (hit[1])
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    break_cause_a: assert property (
        break_req |-> $past(cnt_done) || $past(hit[1]))
        else $error("break without a qualifying hit");
    ch2_hit_a: assert property (
        hit[1] |=> break_req && chan_hit[1] && status_reg[1])
        else $error("channel 2 hit not reported");
    ch2_xy_a: assert property (
        ctrl_reg[1][CTL_AMODE_LSB +: 3] != AM_XBUS
        && ctrl_reg[1][CTL_AMODE_LSB +: 3] != AM_YBUS)
        else $error("channel 2 holds an operand-bus address mode");
    ch2_data_a: assert property (
        ctrl_reg[1][CTL_DMODE_LSB +: 3] == DM_DC)
        else $error("channel 2 holds a data mode");
    count_gate_a: assert property (
        hit[0] && count_reg > 12'h001 && cnt_reg == 12'h000 |=> !break_req || $past(hit[1]))
        else $error("channel 1 broke before its count");
    fetch_only_a: assert property (
        hit[0] && ctrl_reg[0][CTL_AMODE_LSB +: 3] == AM_FETCHB |-> cpu_valid && cpu_fetch)
        else $error("fetch-before hit outside a fetch");
    off_quiet_a: assert property (
        !ctrl_reg[0][CTL_CH_EN] && !ctrl_reg[1][CTL_CH_EN] |=> !break_req)
        else $error("break while both channels disabled");
    spid_rst_a: assert property (
        $fell(srst) |-> spid_reg[0] == RST_SPID && spid_reg[1] == RST_SPID)
        else $error("identifier value not cleared by reset");
    no_mmu_a: assert property (
        !HAS_MMU |-> spid_reg[0] == 8'h00 && spid_reg[1] == 8'h00)
        else $error("identifier stored without memory management");
    wait_one_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

    ch1_brk_c: cover property (hit[0] && cnt_done ##1 break_req);
    ch2_brk_c: cover property (hit[1] ##1 break_req);
    cnt_wait_c: cover property (hit[0] && !cnt_done ##[1:50] cnt_done);
    clr_c: cover property (wr_acc && avs_address == OFS_STATUS ##1 status_reg == 2'h0);
endmodule

// File: dv/hbc_core_model.sv
// Core-side bus model presenting one access per bench request
`timescale 1ns/1ns
module hbc_core_model (
    // Request from the bench
    input  wire logic        go,
    input  wire logic [1:0]  sel,
    input  wire logic [31:0] a,
    input  wire logic [31:0] d,
    input  wire logic [4:0]  x,
    input  wire logic [7:0]  id,
    // Core side
    output logic [3:0]       valid,
    output logic [31:0]      addr,
    output logic [31:0]      data,
    output logic             wr,
    output logic [1:0]       size,
    output logic             fetch,
    output logic             dma,
    output logic [7:0]       id_o
);
    // Idle lines carry the inverse of the last access so stale values never match
    assign valid = go ? 4'h1 << sel : 4'h0;
    assign addr = go ? a : ~a;
    assign data = go ? d : ~d;
    assign {dma, fetch, size, wr} = go ? x : ~x;
    assign id_o = go ? id : ~id;
endmodule

// File: dv/tb.sv
// Self-checking bench for the break-condition matcher
`timescale 1ns/1ns
module tb
    import hbc_pkg::*;
;
    logic        ref_clk, srst, avs_read, avs_write, avs_waitrequest, break_req, go;
    logic        wr, fetch, dma;
    logic [7:0]  avs_address, id, id_o;
    logic [31:0] avs_writedata, avs_readdata, a, d, q, addr, data;
    logic [1:0]  chan_hit, sel, size;
    logic [3:0]  valid;
    logic [4:0]  x;
    int          n_fail, samples_checked, i;
    typedef struct packed {
        logic [13:0] c;
        logic [15:0] ac, m, dc;
        logic [1:0]  s;
        logic [15:0] a, d;
        logic [4:0]  x;
        logic        e;
    } hbc_row_s;
    hbc_row_s rows [19] = '{
        '{14'h2001, 16'h1000, 16'h0, 16'h0, 2'h0, 16'h1000, 16'h0, 5'h04, 1'h1},
        '{14'h2001, 16'h1000, 16'h0, 16'h0, 2'h0, 16'h1004, 16'h0, 5'h04, 1'h0},
        '{14'h2009, 16'h1000, 16'hF, 16'h0, 2'h0, 16'h100C, 16'h0, 5'h04, 1'h1},
        '{14'h200A, 16'h1000, 16'hF, 16'h0, 2'h0, 16'h100C, 16'h0, 5'h0C, 1'h0},
        '{14'h2002, 16'h1000, 16'h0, 16'h0, 2'h0, 16'h1000, 16'h0, 5'h04, 1'h0},
        '{14'h2002, 16'h1000, 16'h0, 16'h0, 2'h0, 16'h1000, 16'h0, 5'h0C, 1'h1},
        '{14'h2003, 16'h1000, 16'h0, 16'h0, 2'h3, 16'h1000, 16'h0, 5'h04, 1'h1},
        '{14'h2004, 16'h1000, 16'h0, 16'h0, 2'h1, 16'h1000, 16'h0, 5'h04, 1'h1},
        '{14'h2005, 16'h1000, 16'h0, 16'h0, 2'h2, 16'h1000, 16'h0, 5'h04, 1'h1},
        '{14'h2010, 16'h0, 16'h0, 16'h55, 2'h0, 16'h0, 16'hAA55, 5'h00, 1'h1},
        '{14'h2010, 16'h0, 16'h0, 16'h55, 2'h0, 16'h0, 16'hAA55, 5'h02, 1'h0},
        '{14'h20B0, 16'h0, 16'hFF, 16'h1200, 2'h0, 16'h0, 16'h12AB, 5'h04, 1'h1},
        '{14'h2040, 16'h0, 16'h0, 16'h77, 2'h1, 16'h0, 16'h77, 5'h04, 1'h1},
        '{14'h2050, 16'h0, 16'h0, 16'h77, 2'h2, 16'h0, 16'h77, 5'h04, 1'h1},
        '{14'h2200, 16'h0, 16'h0, 16'h0, 2'h0, 16'h0, 16'h0, 5'h14, 1'h0},
        '{14'h2400, 16'h0, 16'h0, 16'h0, 2'h0, 16'h0, 16'h0, 5'h14, 1'h1},
        '{14'h2800, 16'h0, 16'h0, 16'h0, 2'h0, 16'h0, 16'h0, 5'h05, 1'h0},
        '{14'h3000, 16'h0, 16'h0, 16'h0, 2'h0, 16'h0, 16'h0, 5'h05, 1'h1},
        '{14'h0001, 16'h1000, 16'h0, 16'h0, 2'h0, 16'h1000, 16'h0, 5'h04, 1'h0}};

    hbc_matcher hbc_matcher_inst (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_valid(valid[0]), .cpu_addr(addr), .cpu_data(data), .cpu_wr(wr), .cpu_size(size),
        .cpu_fetch(fetch), .cpu_dma(dma), .cpu_address_space_identifier(id_o),
        .retire_valid(valid[3]), .retire_pc(addr), .xbus_valid(valid[1]), .xbus_addr(addr),
        .xbus_data(data), .xbus_wr(wr), .ybus_valid(valid[2]), .ybus_addr(addr),
        .ybus_data(data), .ybus_wr(wr), .break_req(break_req), .chan_hit(chan_hit));
    hbc_core_model hbc_core_model_inst (.go(go), .sel(sel), .a(a), .d(d), .x(x), .id(id),
        .valid(valid), .addr(addr), .data(data), .wr(wr), .size(size), .fetch(fetch),
        .dma(dma), .id_o(id_o));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic r, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge ref_clk);
        avs_read <= r;
        avs_write <= !r;
        avs_address <= ad;
        avs_writedata <= wd;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    // One core access, then settle past the edge that registers the hit
    task automatic fire(input logic [1:0] s, input logic [31:0] aa, dd, input logic [4:0] xx,
                        input logic [7:0] ii);
        @(posedge ref_clk);
        go <= 1;
        sel <= s;
        a <= aa;
        d <= dd;
        x <= xx;
        id <= ii;
        @(posedge ref_clk);
        go <= 0;
        @(negedge ref_clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end
    initial begin
        {srst, avs_read, avs_write, avs_address, avs_writedata, go, sel, a, d, x, id} = '0;
        srst = 1;
        n_fail = 0;
        samples_checked = 0;
        repeat (6) @(posedge ref_clk);
        srst <= 0;
        acc(1, OFS_CTRL, 0); chk("ctrl reset", 32'(RST_CTRL), q);
        acc(1, 8'h14, 0); chk("id reset", 32'(RST_SPID), q);
        acc(1, OFS_COUNT, 0); chk("count reset", 32'(RST_COUNT), q);
        acc(1, 8'h80, 0); chk("unmapped", 0, q);
        fire(0, 32'h1000, 0, 5'h04, 0); chk("idle", 0, 32'({break_req, chan_hit}));
        for (i = 0; i < 19; i++) begin
            acc(0, OFS_CTRL, 32'(rows[i].c));
            acc(0, OFS_ADDR, 32'(rows[i].ac));
            acc(0, OFS_AMASK, 32'(rows[i].m));
            acc(0, OFS_DMASK, 32'(rows[i].m));
            acc(0, OFS_DATA, 32'(rows[i].dc));
            fire(rows[i].s, 32'(rows[i].a), 32'(rows[i].d), rows[i].x, 0);
            chk("row hit", 32'(rows[i].e), 32'(chan_hit[0]));
        end
        acc(0, OFS_CTRL, 32'h2000);
        acc(0, OFS_COUNT, 32'h2);
        fire(0, 32'h10, 0, 5'h04, 0); chk("count one", 1, 32'({break_req, chan_hit[0]}));
        fire(0, 32'h10, 0, 5'h04, 0); chk("count two", 3, 32'({break_req, chan_hit[0]}));
        acc(0, OFS_COUNT, 32'h1);
        acc(0, 8'h14, 32'hFF);
        acc(0, OFS_CTRL, 32'h2100);
        fire(0, 0, 0, 5'h04, 8'hFF); chk("id match", 1, 32'(chan_hit[0]));
        fire(0, 0, 0, 5'h04, 8'hFE); chk("id miss", 0, 32'(chan_hit[0]));
        acc(0, OFS_CTRL, 0);
        acc(0, 8'h20, 32'h2004);
        acc(1, 8'h20, 0); chk("ch2 mode", 32'h2000, q);
        acc(0, 8'h2C, 32'h55);
        acc(1, 8'h2C, 0); chk("ch2 data", 0, q);
        fire(0, 32'h40, 0, 5'h04, 0); chk("ch2 hit", 6, 32'({break_req, chan_hit}));
        acc(1, OFS_STATUS, 0);
        chk("status", 3, q);
        acc(0, OFS_STATUS, 3);
        acc(1, OFS_STATUS, 0);
        chk("status clear", 0, q);
        srst <= 1;
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        acc(1, OFS_CH_STRIDE, 0);
        chk("ctrl after reset", 32'(RST_CTRL), q);
        conclude();
    end
endmodule
